// ### apd_pkg.sv
// Purpose: Shared constants and types for the converter power and start-up control
// Assumes: 250 MHz core clock
// Notes:   Command words are 16 bits, shifted MSB first
package apd_pkg;

  // ==========================================================================
  // Command words
  localparam logic [15:0] CMD_SOFT_SLEEP  = 16'h8000;
  localparam logic [3:0]  CMD_CONFIG_NIB  = 4'hA;
  localparam int          FRAME_BITS      = 16;
  localparam int          CFG_BITS        = 12;
  localparam int          CODE_BITS       = 10;

  // ==========================================================================
  // Configuration fields and reset values
  localparam int          CFG_REF_INT_BIT = 11;
  localparam logic [11:0] CFG_RESET       = 12'h000;
  localparam logic [9:0]  CODE_ALL_ONES   = 10'h3FF;
  localparam logic [9:0]  CODE_ALL_ZEROS  = 10'h000;

  // ==========================================================================
  // Timing
  localparam int          CLK_MHZ         = 250;
  localparam int          REF_WAKE_MS     = 20;
  localparam int          REF_WAKE_CYC    = REF_WAKE_MS * 1000 * CLK_MHZ;
  localparam real         INT_MAX_US      = 3.5;
  localparam int          INT_MAX_CYC     = $rtoi(INT_MAX_US * CLK_MHZ);
  localparam int          SYNC_LAG_CYC    = 4;
  localparam int          CONV_CYC        = INT_MAX_CYC - SYNC_LAG_CYC;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [3:0]  cmd;
    logic [11:0] payload;
  } apd_word_t;

  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_SOFT  = 2'b01,
    ST_HARD  = 2'b10
  } apd_pwr_t;

endpackage

// ### apd_sync.sv
// Purpose: Two-flop synchroniser for a group of pins
// Assumes: Each bit is an independent level
// Notes:   Reset value is a parameter so idle-high pins start high
`timescale 1ns/100ps
`default_nettype none
module apd_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  // ==========================================================================
  // Per-bit stages
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta      <= INIT[g];
          o_sync[g] <= INIT[g];
        end else begin
          meta      <= i_async[g];
          o_sync[g] <= meta;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### apd_top.sv
// Purpose: Power-down, wake-up and initialisation control of a serial SAR converter
// Assumes: Serial clock, select, frame sync and trigger are asynchronous pins
// Notes:   Analog core and reference are steered by enable outputs
// Function
// - Command 8000h enters software sleep
// - Hard sleep pin powers down asynchronously
// - Both sleeps switch off whole device, reference
// - Reference needs 20 ms after wake
// - Core auto powers down when not accessed
// - Auto power-down keeps internal reference running
// - Configuration kept through every power-down
// - Sweep restarts from start after power-down
// - Hard or soft sleep empties result FIFO
// - First conversion after wake is invalid
// - Interrupt low within 3.5 us of 16th edge
// - Over-range gives all ones, under gives zeros
// - Config write carries 12 bits, no conversion
`timescale 1ns/100ps
`default_nettype none
module apd_top
  import apd_pkg::*;
#(
  parameter int REF_WAKE = REF_WAKE_CYC,
  parameter int CONV     = CONV_CYC
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_sclk,
  input  wire logic                 i_frame_sync,
  input  wire logic                 i_serial_in,
  input  wire logic                 i_hard_sleep_n,
  input  wire logic                 i_conv_trigger_n,
  input  wire logic [CODE_BITS-1:0] i_raw_code,
  input  wire logic                 i_above_upper,
  input  wire logic                 i_below_lower,
  output logic                      o_serial_out,
  output logic                      o_serial_out_oe,
  output logic                      o_int_n,
  output logic                      o_ref_enable,
  output logic                      o_ref_ready,
  output logic                      o_core_enable,
  output logic                      o_fifo_clear,
  output logic                      o_sweep_restart,
  output logic                      o_host_known,
  output logic [CFG_BITS-1:0]       o_config,
  output logic [CODE_BITS-1:0]      o_result,
  output logic                      o_result_invalid
);

  // ==========================================================================
  // Reset release and pin synchronisers
  logic       rst_meta;
  logic       rst_n;
  logic [4:0] pins;
  logic       cs_n;
  logic       sclk;
  logic       fsync;
  logic       serial_in;
  logic       trig_n;
  logic       sclk_d;
  logic       cs_d;
  logic       trig_d;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  apd_sync #(.W(5), .INIT(5'h16)) u_sync (
    .i_clk   (i_core_clk),
    .i_rst_n (rst_n),
    .i_async ({i_conv_trigger_n, i_serial_in, i_frame_sync, i_cs_n, i_sclk}),
    .o_sync  (pins)
  );

  assign {trig_n, serial_in, fsync, cs_n, sclk} = pins;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
      trig_d <= 1'b1;
    end else begin
      sclk_d <= sclk;
      cs_d   <= cs_n;
      trig_d <= trig_n;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic trig_rise;
  assign sclk_rise = sclk & ~sclk_d;
  assign sclk_fall = ~sclk & sclk_d;
  assign cs_fall   = ~cs_n & cs_d;
  assign cs_rise   = cs_n & ~cs_d;
  assign trig_rise = trig_n & ~trig_d;

  // ==========================================================================
  // Frame receiver
  logic        fs_used;
  logic        frame_on;
  logic [4:0]  bit_cnt;
  logic [15:0] shift_in;
  logic        in_edge;
  logic        out_edge;
  logic        word_done;
  apd_word_t   word;

  // Frame sync tied high picks rising-edge capture, a used frame sync falling
  assign in_edge   = fs_used ? sclk_fall : sclk_rise;
  assign out_edge  = fs_used ? sclk_rise : sclk_fall;
  assign word_done = frame_on && in_edge && (bit_cnt == 5'(FRAME_BITS - 1));
  assign word      = apd_word_t'({shift_in[14:0], serial_in});

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_used  <= 1'b0;
      frame_on <= 1'b0;
      bit_cnt  <= 5'h00;
      shift_in <= 16'h0000;
    end else if (cs_fall) begin
      fs_used  <= ~fsync;
      frame_on <= 1'b1;
      bit_cnt  <= 5'h00;
    end else if (cs_n || word_done) begin
      frame_on <= 1'b0;
    end else if (frame_on && in_edge) begin
      shift_in <= {shift_in[14:0], serial_in};
      bit_cnt  <= bit_cnt + 5'h01;
    end
  end

  logic is_sleep_cmd;
  logic is_cfg_cmd;
  assign is_sleep_cmd = word_done && (word == CMD_SOFT_SLEEP);
  assign is_cfg_cmd   = word_done && (word.cmd == CMD_CONFIG_NIB);

  // ==========================================================================
  // Power state
  apd_pwr_t pwr;
  apd_pwr_t next_pwr;
  logic     hard_req;

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      ST_AWAKE: if (is_sleep_cmd) next_pwr = ST_SOFT;
      ST_SOFT:  if (word_done && !is_sleep_cmd) next_pwr = ST_AWAKE;
      ST_HARD:  if (hard_req) next_pwr = ST_AWAKE;
      default:  next_pwr = ST_AWAKE;
    endcase
  end

  // The pin forces sleep with no clock or frame involved
  always_ff @(posedge i_core_clk or negedge rst_n or negedge i_hard_sleep_n) begin
    if (!rst_n) begin
      pwr      <= ST_AWAKE;
      hard_req <= 1'b0;
    end else if (!i_hard_sleep_n) begin
      pwr      <= ST_HARD;
      hard_req <= 1'b0;
    end else begin
      pwr      <= next_pwr;
      hard_req <= 1'b1;
    end
  end

  logic asleep;
  logic asleep_d;
  assign asleep = (pwr != ST_AWAKE);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep_d        <= 1'b0;
      o_fifo_clear    <= 1'b0;
      o_sweep_restart <= 1'b0;
    end else begin
      asleep_d        <= asleep;
      o_fifo_clear    <= asleep & ~asleep_d;
      o_sweep_restart <= asleep & ~asleep_d;
    end
  end

  // ==========================================================================
  // Configuration and host type
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_config     <= CFG_RESET;
      o_host_known <= 1'b0;
    end else if (is_cfg_cmd && !asleep) begin
      o_config     <= word.payload;
      o_host_known <= 1'b1;
    end
  end

  // ==========================================================================
  // Reference control and wake timer
  logic [31:0] ref_cnt;

  always_ff @(posedge i_core_clk or negedge rst_n or negedge i_hard_sleep_n) begin
    if (!rst_n) begin
      o_ref_enable <= 1'b0;
    end else if (!i_hard_sleep_n) begin
      o_ref_enable <= 1'b0;
    end else begin
      o_ref_enable <= ~asleep & o_config[CFG_REF_INT_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt     <= 32'h0000_0000;
      o_ref_ready <= 1'b0;
    end else if (!o_ref_enable) begin
      ref_cnt     <= 32'h0000_0000;
      o_ref_ready <= 1'b0;
    end else if (ref_cnt < 32'(REF_WAKE)) begin
      ref_cnt     <= ref_cnt + 32'h0000_0001;
    end else begin
      o_ref_ready <= 1'b1;
    end
  end

  // ==========================================================================
  // Conversion, interrupt and result
  logic        busy;
  logic [15:0] conv_cnt;
  logic        first_pending;
  logic        start;

  // Config writes and sleep frames never convert
  assign start = ~asleep && ((word_done && !is_cfg_cmd && !is_sleep_cmd) || trig_rise);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      conv_cnt <= 16'h0000;
    end else if (asleep) begin
      busy     <= 1'b0;
    end else if (start && !busy) begin
      busy     <= 1'b1;
      conv_cnt <= 16'h0000;
    end else if (busy) begin
      conv_cnt <= conv_cnt + 16'h0001;
      if (conv_cnt == 16'(CONV - 1)) busy <= 1'b0;
    end
  end

  logic conv_end;
  assign conv_end = busy && !asleep && (conv_cnt == 16'(CONV - 1));

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_int_n          <= 1'b1;
      o_result         <= CODE_ALL_ZEROS;
      o_result_invalid <= 1'b0;
      first_pending    <= 1'b1;
    end else begin
      if (asleep) begin
        first_pending <= 1'b1;
      end
      if (conv_end) begin
        o_int_n          <= 1'b0;
        o_result_invalid <= first_pending;
        first_pending    <= 1'b0;
        if (i_above_upper) begin
          o_result <= CODE_ALL_ONES;
        end else if (i_below_lower) begin
          o_result <= CODE_ALL_ZEROS;
        end else begin
          o_result <= i_raw_code;
        end
      end else if (cs_fall || asleep) begin
        o_int_n <= 1'b1;
      end
    end
  end

  // Core runs only while selected, triggered or converting
  always_ff @(posedge i_core_clk or negedge rst_n or negedge i_hard_sleep_n) begin
    if (!rst_n) begin
      o_core_enable <= 1'b0;
    end else if (!i_hard_sleep_n) begin
      o_core_enable <= 1'b0;
    end else begin
      o_core_enable <= ~asleep & (~cs_n | ~trig_n | busy);
    end
  end

  // ==========================================================================
  // Serial output
  logic [CODE_BITS-1:0] shift_out;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out       <= CODE_ALL_ZEROS;
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else begin
      o_serial_out_oe <= ~cs_n & ~cs_rise;
      if (cs_fall) begin
        shift_out    <= {o_result[CODE_BITS-2:0], 1'b0};
        o_serial_out <= o_result[CODE_BITS-1];
      end else if (frame_on && out_edge) begin
        o_serial_out <= shift_out[CODE_BITS-1];
        shift_out    <= {shift_out[CODE_BITS-2:0], 1'b0};
      end
    end
  end

endmodule
`default_nettype wire

// ### apd_monitor.sv
// Purpose: Port assertions for the power control block
// Assumes: Single core clock domain
// Notes:   Bound into every apd_top
`timescale 1ns/100ps
`default_nettype none
module apd_monitor
  import apd_pkg::*;
#(
  parameter int REF_WAKE = REF_WAKE_CYC
) (
  input wire logic                 i_core_clk,
  input wire logic                 i_resetn,
  input wire logic                 i_hard_sleep_n,
  input wire logic                 i_above_upper,
  input wire logic                 i_below_lower,
  input wire logic                 o_int_n,
  input wire logic                 o_ref_enable,
  input wire logic                 o_ref_ready,
  input wire logic                 o_core_enable,
  input wire logic                 o_fifo_clear,
  input wire logic                 o_sweep_restart,
  input wire logic [CFG_BITS-1:0]  o_config,
  input wire logic [CODE_BITS-1:0] o_result
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  int ref_cnt;
  // ==========
  // Cycles since the reference was switched on
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) ref_cnt <= 0;
    else if (!o_ref_enable) ref_cnt <= 0;
    else if (ref_cnt < REF_WAKE) ref_cnt <= ref_cnt + 1;
  end
  sequence s_over;
    i_above_upper ##1 i_above_upper ##1 $fell(o_int_n);
  endsequence
  sequence s_under;
    i_below_lower ##1 i_below_lower ##1 $fell(o_int_n);
  endsequence
  a_hard_sleep_off:
    assert property (!i_hard_sleep_n |-> !o_ref_enable && !o_core_enable)
    else $error("power on in hard sleep");
  a_ref_settle_time:
    assert property (o_ref_ready && o_ref_enable |-> ref_cnt >= REF_WAKE)
    else $error("reference ready too early");
  a_ref_int_only:
    assert property (o_ref_enable |-> o_config[CFG_REF_INT_BIT] || $past(o_config[CFG_REF_INT_BIT]))
    else $error("reference on while external");
  a_clear_pair:
    assert property (o_fifo_clear || o_sweep_restart |-> o_fifo_clear && o_sweep_restart)
    else $error("clear and restart apart");
  a_clear_pulse:
    assert property (o_fifo_clear |=> !o_fifo_clear)
    else $error("clear pulse too long");
  a_sleep_all_off:
    assert property (o_fifo_clear |-> !o_core_enable && !o_ref_enable)
    else $error("power on at sleep entry");
  a_config_kept:
    assert property (o_fifo_clear |-> $stable(o_config))
    else $error("config lost at sleep");
  a_over_all_ones:
    assert property (s_over |-> o_result == CODE_ALL_ONES)
    else $error("over range not clamped");
  a_under_all_zero:
    assert property (s_under |-> o_result == CODE_ALL_ZEROS)
    else $error("under range not clamped");
endmodule
bind apd_top apd_monitor #(.REF_WAKE(REF_WAKE)) i_mon (
  .i_core_clk, .i_resetn, .i_hard_sleep_n, .i_above_upper, .i_below_lower,
  .o_int_n, .o_ref_enable, .o_ref_ready, .o_core_enable, .o_fifo_clear,
  .o_sweep_restart, .o_config, .o_result
);
`default_nettype wire

// ### apd_host_model.sv
// Purpose: Host serial port driving 16-bit frames
// Assumes: Serial clock of 64 ns, idle low between frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module apd_host_model (
  output var logic o_cs_n,
  output var logic o_sclk,
  output var logic o_fs,
  output var logic o_sdi
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_fs   = 1'b1;
    o_sdi  = 1'b0;
  end
  // ==========
  // One frame, MSB first, frame sync optional
  task automatic send(input logic [15:0] w, input bit use_fs);
    #1.7;
    o_cs_n = 1'b0;
    o_fs   = !use_fs;
    #32 o_fs = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      if (!use_fs) o_sdi = w[i];
      #32 o_sclk = 1'b1;
      // With frame sync in use the bit is taken on the falling edge
      if (use_fs) o_sdi = w[i];
      if (use_fs && i < 15) o_fs = 1'b0;
      #32 o_sclk = 1'b0;
    end
    #32 o_cs_n = 1'b1;
    o_fs  = 1'b1;
    o_sdi = !o_sdi;
    #128;
  endtask
endmodule
`default_nettype wire

// ### apd_top_tb_top.sv
// Purpose: Self-checking bench for the power control block
// Assumes: Short reference wake and conversion counts
// Notes:   Host frames come from the partner model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module apd_top_tb_top;
  import apd_pkg::*;
  localparam int RW = 200;
  logic clk = 1'b0, rst_n = 1'b0, hs_n = 1'b1, trg_n = 1'b1, above = 1'b0, below = 1'b0;
  logic [9:0] raw = 10'h000;
  logic cs_n, sclk, fs, serial_in, serial_out, oe, int_n, ref_en, ref_rdy, core_en, clr, rst_sw, known, inval;
  logic [11:0] cfg;
  logic [9:0] res;
  logic [9:0] last_res = 10'h000;
  int mismatches = 0, comparisons = 0, cyc = 0, clr_cnt = 0, sw_cnt = 0;
  always #2 clk = ~clk;
  apd_host_model i_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_fs(fs), .o_sdi(serial_in));
  apd_top #(.REF_WAKE(RW), .CONV(20)) i_dut (
    .i_core_clk(clk), .i_resetn(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_frame_sync(fs),
    .i_serial_in(serial_in), .i_hard_sleep_n(hs_n), .i_conv_trigger_n(trg_n), .i_raw_code(raw),
    .i_above_upper(above), .i_below_lower(below), .o_serial_out(serial_out),
    .o_serial_out_oe(oe), .o_int_n(int_n), .o_ref_enable(ref_en), .o_ref_ready(ref_rdy),
    .o_core_enable(core_en), .o_fifo_clear(clr), .o_sweep_restart(rst_sw),
    .o_host_known(known), .o_config(cfg), .o_result(res), .o_result_invalid(inval));
  always @(posedge clk) begin
    cyc++;
    if (clr === 1'b1) clr_cnt++;
    if (rst_sw === 1'b1) sw_cnt++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_int();
    for (int n = 0; n < INT_MAX_CYC && int_n !== 1'b0; n++) @(posedge clk);
  endtask
  // ==========
  // Scenarios
  task automatic t_conv(input logic [9:0] r, input logic a, b, input logic [9:0] e,
                        input logic iv);
    @(posedge clk);
    raw <= r; above <= a; below <= b;
    fork
      i_host.send(16'h1234, 1'b1);
      begin
        repeat (12) @(posedge clk);
        `CHK({oe, serial_out}, {1'b1, last_res[9]})
      end
    join
    wait_int();
    `CHK(int_n, 1'b0)
    `CHK(res, e)
    `CHK(inval, iv)
    last_res = e;
  endtask
  task automatic t_init();
    i_host.send(16'hA000, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(known, 1'b1)
    `CHK(int_n, 1'b1)
    i_host.send(16'hA8A5, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(cfg, 12'h8A5)
    `CHK(ref_rdy, 1'b0)
    repeat (RW + 8) @(posedge clk);
    `CHK({ref_en, ref_rdy, core_en}, 3'b110)
  endtask
  task automatic t_soft();
    int c0 = clr_cnt;
    int s0 = sw_cnt;
    i_host.send(CMD_SOFT_SLEEP, 1'b1);
    repeat (8) @(posedge clk);
    `CHK(clr_cnt, c0 + 1)
    `CHK(sw_cnt, s0 + 1)
    `CHK({ref_en, core_en}, 2'b00)
    i_host.send(16'h1234, 1'b0);
    repeat (40) @(posedge clk);
    `CHK(int_n, 1'b1)
    `CHK(cfg, 12'h8A5)
    `CHK(ref_en, 1'b1)
    `CHK(ref_rdy, 1'b0)
    t_conv(10'h0F0, 1'b0, 1'b0, 10'h0F0, 1'b1);
  endtask
  task automatic t_hard();
    int c0 = clr_cnt;
    int s0 = sw_cnt;
    @(posedge clk);
    hs_n <= 1'b0;
    #1 `CHK({ref_en, core_en}, 2'b00)
    repeat (8) @(posedge clk);
    `CHK(clr_cnt, c0 + 1)
    `CHK(sw_cnt, s0 + 1)
    `CHK(cfg, 12'h8A5)
    hs_n <= 1'b1;
    repeat (8) @(posedge clk);
    trg_n <= 1'b0;
    repeat (200) @(posedge clk);
    `CHK(core_en, 1'b1)
    trg_n <= 1'b1;
    raw   <= 10'h1C7;
    wait_int();
    `CHK(res, 10'h1C7)
    `CHK(inval, 1'b1)
    repeat (900) @(posedge clk);
    trg_n <= 1'b0;
    repeat (200) @(posedge clk);
    trg_n <= 1'b1;
    raw   <= 10'h2D3;
    repeat (40) @(posedge clk);
    `CHK(res, 10'h2D3)
    `CHK(inval, 1'b0)
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_init();
    t_conv(10'h155, 1'b0, 1'b0, 10'h155, 1'b1);
    t_conv(10'h2AA, 1'b1, 1'b0, CODE_ALL_ONES, 1'b0);
    t_conv(10'h2AA, 1'b0, 1'b1, CODE_ALL_ZEROS, 1'b0);
    t_soft();
    t_hard();
    finish_test();
  end
endmodule
`default_nettype wire
